// [rtl/switch_check_params.svh]
// Constants of the switch-interface configuration checker: field positions and codes.
// Assumes it is included by bare name from the package and the checker module.
`ifndef SWITCH_CHECK_PARAMS_SVH
`define SWITCH_CHECK_PARAMS_SVH

// Number of constraint flags and of ordered threshold pairs.
`define SCC_RULE_CNT      10
`define SCC_PAIR_CNT      7
`define SCC_THR_W         10
`define SCC_IN_CNT        24

// Input groups of the 4x4 matrix: sink rows and source columns.
`define SCC_SINK_LSB      4
`define SCC_SRC_LSB       10
`define SCC_GRP_W         4
`define SCC_GRP_ONES      4'hf
`define SCC_GRP_ZERO      4'h0

// Wetting-current fields: sink and source code positions of each pair.
`define SCC_WC_W          3
`define SCC_WC_SINK0_LSB  18
`define SCC_WC_SRC0_LSB   6
`define SCC_WC_SINK1_LSB  21
`define SCC_WC_SRC1_LSB   9
`define SCC_WC_SINK2_LSB  0
`define SCC_WC_SRC2_LSB   12
`define SCC_WC_PAIR_CNT   3

// Wetting-current codes that matter under an expected thermal warning.
`define SCC_WC_1MA        3'h1
`define SCC_WC_2MA        3'h2
`define SCC_WC_2MA_SINK   3'h3

// Flag positions (flag n-1 belongs to constraint n).
`define SCC_F_L2          0
`define SCC_F_L3          1
`define SCC_F_CHAIN       2
`define SCC_F_SUPPLY      3
`define SCC_F_POLL        4
`define SCC_F_ENABLE      5
`define SCC_F_MODE        6
`define SCC_F_ROLE        7
`define SCC_F_WC_ORDER    8
`define SCC_F_WC_THERMAL  9

// Pair positions in the ordering comparator.
`define SCC_P_L2          0
`define SCC_P_L3_HM       1
`define SCC_P_L3_ML       2
`define SCC_P_NINE        3
`define SCC_P_EIGHT       4
`define SCC_P_SUP0        5
`define SCC_P_SUP1        6

`endif

// [rtl/switch_check_pkg.sv]
// Types shared by the configuration checker modules.
// Assumes the params header sits beside it on the include path.
`include "switch_check_params.svh"

package switch_check_pkg;

	// Matrix-size field encoding of the device.
	typedef enum logic [1:0] {
		MATRIX_NONE = 2'h0,
		MATRIX_4X4  = 2'h1,
		MATRIX_5X5  = 2'h2,
		MATRIX_6X6  = 2'h3
	} matrix_size_e;

	// Per-input conversion-mode bit encoding.
	typedef enum logic {
		CONV_COMPARATOR = 1'b0,
		CONV_ADC        = 1'b1
	} conv_mode_e;

	typedef logic [`SCC_WC_W-1:0]     wc_code_t;
	typedef logic [`SCC_RULE_CNT-1:0] flags_t;

endpackage

// [rtl/switch_config_rule_checker.sv]
// Host-side checker of a switch-detection interface configuration.
// Assumes the shadows mirror what the host writes to the device, on clk_i.
`timescale 1ns/1ns
`default_nettype none

`include "switch_check_params.svh"

module switch_config_rule_checker
	import switch_check_pkg::*;
#(
	parameter int THR_W = `SCC_THR_W
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             check_valid_i,
	input  wire logic             clear_i,
	input  wire logic [THR_W-1:0] level2_low_threshold_i,
	input  wire logic [THR_W-1:0] level2_high_threshold_i,
	input  wire logic [THR_W-1:0] level3_low_threshold_i,
	input  wire logic [THR_W-1:0] level3_mid_threshold_i,
	input  wire logic [THR_W-1:0] level3_high_threshold_i,
	input  wire logic [THR_W-1:0] eighth_threshold_i,
	input  wire logic [THR_W-1:0] ninth_threshold_i,
	input  wire logic [THR_W-1:0] supply_set0_low_threshold_i,
	input  wire logic [THR_W-1:0] supply_set0_high_threshold_i,
	input  wire logic [THR_W-1:0] supply_set1_low_threshold_i,
	input  wire logic [THR_W-1:0] supply_set1_high_threshold_i,
	input  wire logic [1:0]       matrix_size_i,
	input  wire logic             poll_enable_i,
	input  wire logic [23:0]      input_enable_i,
	input  wire logic [23:0]      conversion_mode_i,
	input  wire logic [23:0]      sink_select_i,
	input  wire logic [23:0]      wetting_current_config_a_i,
	input  wire logic [23:0]      wetting_current_config_b_i,
	input  wire logic             thermal_warning_event_i,
	output logic [`SCC_RULE_CNT-1:0] violation_o,
	output logic                  config_ok_o,
	output logic                  matrix_active_o
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------

	// Thresholds are at least one bit and no wider than a device field.
	generate
		if (THR_W < 1 || THR_W > 16) begin : g_bad_width
			$error("THR_W must lie between 1 and 16.");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------

	// Picks one wetting-current code out of a configuration word.
	function automatic wc_code_t wc_field(input logic [23:0] word, input int lsb);
		wc_field = word[lsb +: `SCC_WC_W];
	endfunction

	// True when a sink code does not exceed its source code.
	function automatic logic wc_order_bad(input wc_code_t sink, input wc_code_t src);
		wc_order_bad = !(sink > src);
	endfunction

	// True when a pair breaks the thermal-warning limits on its source code or on the sink code that the source code needs.
	function automatic logic wc_thermal_bad(input wc_code_t sink, input wc_code_t src);
		logic bad;
		bad = 1'b0;
		if (src == `SCC_WC_1MA) begin
			bad = !(sink > `SCC_WC_1MA);
		end else if (src == `SCC_WC_2MA) begin
			bad = (sink != `SCC_WC_2MA_SINK);
		end else begin
			bad = 1'b1;
		end
		wc_thermal_bad = bad;
	endfunction

	// ----------------------------------------------------------------
	// Threshold ordering
	// ----------------------------------------------------------------

	threshold_pairs_if #(.N(`SCC_PAIR_CNT), .W(THR_W)) pairs ();

	// Upper and lower sides of every ordered pair; supply pairs are strict.
	always_comb begin
		pairs.upper[`SCC_P_L2]    = level2_high_threshold_i;
		pairs.lower[`SCC_P_L2]    = level2_low_threshold_i;
		pairs.upper[`SCC_P_L3_HM] = level3_high_threshold_i;
		pairs.lower[`SCC_P_L3_HM] = level3_mid_threshold_i;
		pairs.upper[`SCC_P_L3_ML] = level3_mid_threshold_i;
		pairs.lower[`SCC_P_L3_ML] = level3_low_threshold_i;
		pairs.upper[`SCC_P_NINE]  = ninth_threshold_i;
		pairs.lower[`SCC_P_NINE]  = eighth_threshold_i;
		pairs.upper[`SCC_P_EIGHT] = eighth_threshold_i;
		pairs.lower[`SCC_P_EIGHT] = level3_high_threshold_i;
		pairs.upper[`SCC_P_SUP0]  = supply_set0_high_threshold_i;
		pairs.lower[`SCC_P_SUP0]  = supply_set0_low_threshold_i;
		pairs.upper[`SCC_P_SUP1]  = supply_set1_high_threshold_i;
		pairs.lower[`SCC_P_SUP1]  = supply_set1_low_threshold_i;
		pairs.strict              = '0;
		pairs.strict[`SCC_P_SUP0] = 1'b1;
		pairs.strict[`SCC_P_SUP1] = 1'b1;
	end

	threshold_order_compare #(
		.N (`SCC_PAIR_CNT)
	) u_compare (
		.pairs (pairs.judge)
	);

	// ----------------------------------------------------------------
	// Matrix prerequisites
	// ----------------------------------------------------------------

	logic                   matrix4;
	logic [`SCC_GRP_W-1:0]  en_sink;
	logic [`SCC_GRP_W-1:0]  en_src;
	logic [`SCC_GRP_W-1:0]  mode_sink;
	logic [`SCC_GRP_W-1:0]  mode_src;
	logic [`SCC_GRP_W-1:0]  role_sink;
	logic [`SCC_GRP_W-1:0]  role_src;
	wc_code_t               wc_sink [`SCC_WC_PAIR_CNT];
	wc_code_t               wc_src  [`SCC_WC_PAIR_CNT];
	logic [`SCC_WC_PAIR_CNT-1:0] wc_order_hit;
	logic [`SCC_WC_PAIR_CNT-1:0] wc_thermal_hit;

	// Only the 4x4 encoding arms the matrix checks; other sizes are not judged.
	assign matrix4   = (matrix_size_e'(matrix_size_i) == MATRIX_4X4);
	assign en_sink   = input_enable_i[`SCC_SINK_LSB +: `SCC_GRP_W];
	assign en_src    = input_enable_i[`SCC_SRC_LSB +: `SCC_GRP_W];
	assign mode_sink = conversion_mode_i[`SCC_SINK_LSB +: `SCC_GRP_W];
	assign mode_src  = conversion_mode_i[`SCC_SRC_LSB +: `SCC_GRP_W];
	assign role_sink = sink_select_i[`SCC_SINK_LSB +: `SCC_GRP_W];
	assign role_src  = sink_select_i[`SCC_SRC_LSB +: `SCC_GRP_W];

	// Sink and source codes of the three wetting-current pairs.
	always_comb begin
		wc_sink[0] = wc_field(wetting_current_config_a_i, `SCC_WC_SINK0_LSB);
		wc_src[0]  = wc_field(wetting_current_config_a_i, `SCC_WC_SRC0_LSB);
		wc_sink[1] = wc_field(wetting_current_config_a_i, `SCC_WC_SINK1_LSB);
		wc_src[1]  = wc_field(wetting_current_config_a_i, `SCC_WC_SRC1_LSB);
		wc_sink[2] = wc_field(wetting_current_config_b_i, `SCC_WC_SINK2_LSB);
		wc_src[2]  = wc_field(wetting_current_config_a_i, `SCC_WC_SRC2_LSB);
	end

	// Per-pair wetting-current checks.
	genvar p;
	generate
		for (p = 0; p < `SCC_WC_PAIR_CNT; p++) begin : g_wc
			assign wc_order_hit[p]   = wc_order_bad(wc_sink[p], wc_src[p]);
			assign wc_thermal_hit[p] = wc_thermal_bad(wc_sink[p], wc_src[p]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Violation evaluation
	// ----------------------------------------------------------------

	flags_t hit;

	// Each flag's raw condition, taken only while the shadows are valid.
	always_comb begin
		hit = '0;
		if (check_valid_i) begin
			hit[`SCC_F_L2]     = !pairs.holds[`SCC_P_L2];
			hit[`SCC_F_L3]     = !(pairs.holds[`SCC_P_L3_HM]
			                       && pairs.holds[`SCC_P_L3_ML]);
			hit[`SCC_F_CHAIN]  = !(pairs.holds[`SCC_P_NINE]
			                       && pairs.holds[`SCC_P_EIGHT]
			                       && pairs.holds[`SCC_P_L3_HM]
			                       && pairs.holds[`SCC_P_L3_ML]);
			hit[`SCC_F_SUPPLY] = !(pairs.holds[`SCC_P_SUP0]
			                       && pairs.holds[`SCC_P_SUP1]);
			if (matrix4) begin
				hit[`SCC_F_POLL]   = !poll_enable_i;
				hit[`SCC_F_ENABLE] = (en_sink != `SCC_GRP_ONES)
				                     || (en_src != `SCC_GRP_ONES);
				hit[`SCC_F_MODE]   = (mode_sink != `SCC_GRP_ZERO)
				                     || (mode_src != `SCC_GRP_ZERO);
				hit[`SCC_F_ROLE]   = (role_sink != `SCC_GRP_ONES)
				                     || (role_src != `SCC_GRP_ZERO);
				hit[`SCC_F_WC_ORDER]   = |wc_order_hit;
				hit[`SCC_F_WC_THERMAL] = thermal_warning_event_i
				                         && (|wc_thermal_hit);
			end
		end
	end

	// ----------------------------------------------------------------
	// Sticky flags
	// ----------------------------------------------------------------

	flags_t violation_nxt;

	// A new violation in the cycle of a clear still sets its flag.
	assign violation_nxt = (violation_o & ~{`SCC_RULE_CNT{clear_i}}) | hit;

	// Flag register.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			violation_o <= '0;
		end else begin
			violation_o <= violation_nxt;
		end
	end

	// Summary: no flag standing after this edge.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			config_ok_o <= 1'b1;
		end else begin
			config_ok_o <= ~|violation_nxt;
		end
	end

	// Shows whether matrix checks are currently armed.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			matrix_active_o <= 1'b0;
		end else begin
			matrix_active_o <= matrix4;
		end
	end

endmodule

`default_nettype wire

// [rtl/threshold_order_compare.sv]
// Ordering comparator: tells for each pair whether upper sits above lower, or level with it where the pair allows equality.
// Assumes its inputs are stable register shadows in the same clock domain.
`timescale 1ns/1ns
`default_nettype none

module threshold_order_compare #(
	parameter int N = 7
) (
	threshold_pairs_if.judge pairs
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------

	// At least one pair is needed for the comparator to mean anything.
	generate
		if (N < 1) begin : g_bad_count
			$error("N must be at least 1.");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pair comparison
	// ----------------------------------------------------------------

	// Each pair is strict or allows equality, as the source decides.
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pair
			assign pairs.holds[i] = pairs.strict[i] ? (pairs.upper[i] > pairs.lower[i])
			                                        : (pairs.upper[i] >= pairs.lower[i]);
		end
	endgenerate

endmodule

`default_nettype wire

// [rtl/threshold_pairs_if.sv]
// Carrier for ordered threshold pairs between the checker and its comparator.
// Assumes both ends agree on pair count and threshold width.
`timescale 1ns/1ns
`default_nettype none

interface threshold_pairs_if #(
	parameter int N = 7,
	parameter int W = 10
);
	logic [W-1:0] upper [N];
	logic [W-1:0] lower [N];
	logic [N-1:0] strict;
	logic [N-1:0] holds;

	modport source (output upper, output lower, output strict, input holds);
	modport judge  (input upper, input lower, input strict, output holds);
endinterface

`default_nettype wire

// [tb/cfg_shadow_model.sv]
// Shadow model of the configuration the host has written into the device.
// Assumes one write per clock edge; reset clears every shadow to zero.
`timescale 1ns/1ns
`default_nettype none

module cfg_shadow_model #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	// Fields are held bit for bit, so matrix and mode codes keep their meaning.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) q_o <= '0;
		else q_o <= d_i;
	end
endmodule

`default_nettype wire

// [tb/switch_config_rule_checker_chk.sv]
// Assertions on the configuration checker, bound to its top module.
// Assumes the single clock clk_i with rstn_i as asynchronous reset.
`timescale 1ns/1ns
`default_nettype none

module switch_config_rule_checker_chk
	import switch_check_pkg::*;
#(
	parameter int THR_W = 10
) (
	input wire logic clk_i, rstn_i, check_valid_i, clear_i,
	input wire logic [THR_W-1:0] level2_low_threshold_i, level2_high_threshold_i,
	input wire logic [THR_W-1:0] level3_low_threshold_i, level3_mid_threshold_i,
	input wire logic [THR_W-1:0] level3_high_threshold_i, eighth_threshold_i,
	input wire logic [THR_W-1:0] ninth_threshold_i, supply_set0_low_threshold_i,
	input wire logic [THR_W-1:0] supply_set0_high_threshold_i, supply_set1_low_threshold_i,
	input wire logic [THR_W-1:0] supply_set1_high_threshold_i,
	input wire logic [1:0]       matrix_size_i,
	input wire logic             poll_enable_i, thermal_warning_event_i,
	input wire logic [23:0]      input_enable_i, conversion_mode_i, sink_select_i,
	input wire logic [23:0]      wetting_current_config_a_i, wetting_current_config_b_i,
	input wire logic [9:0]       violation_o,
	input wire logic             config_ok_o, matrix_active_o
);
	// ----------------------------------------
	// Flag checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Shorthands: a valid sample in 4x4 mode and the two wetting words.
	wire logic        mx = check_valid_i && matrix_size_i == MATRIX_4X4;
	wire logic [23:0] wa = wetting_current_config_a_i;
	wire logic [23:0] wb = wetting_current_config_b_i;
	// A source code other than 1 or 2 is refused; code 2 needs sink code 3.
	function automatic logic heat_bad(input logic [2:0] k, input logic [2:0] r);
		return r == 3'h1 ? k <= 3'h1 : r == 3'h2 ? k != 3'h3 : 1'b1;
	endfunction
	sequence s_quiet_clear;
		clear_i && !check_valid_i;
	endsequence
	AST_L2: assert property (
		check_valid_i && level2_high_threshold_i < level2_low_threshold_i |=> violation_o[0]
	) else $error("level2 flag not set");
	AST_L3: assert property (
		check_valid_i && !(level3_high_threshold_i >= level3_mid_threshold_i &&
		level3_mid_threshold_i >= level3_low_threshold_i) |=> violation_o[1]
	) else $error("level3 flag not set");
	AST_CHAIN: assert property (
		check_valid_i && (ninth_threshold_i < eighth_threshold_i ||
		eighth_threshold_i < level3_high_threshold_i) |=> violation_o[2]
	) else $error("chain flag not set");
	AST_SUPPLY: assert property (
		check_valid_i && (supply_set0_high_threshold_i <= supply_set0_low_threshold_i ||
		supply_set1_high_threshold_i <= supply_set1_low_threshold_i) |=> violation_o[3]
	) else $error("supply flag not set");
	AST_POLL: assert property (
		mx && !poll_enable_i |=> violation_o[4]
	) else $error("poll flag not set");
	AST_ENABLE: assert property (
		mx && (input_enable_i[13:10] & input_enable_i[7:4]) != 4'hf |=> violation_o[5]
	) else $error("enable flag not set");
	AST_MODE: assert property (
		mx && |{conversion_mode_i[13:10], conversion_mode_i[7:4]} |=> violation_o[6]
	) else $error("mode flag not set");
	AST_ROLE: assert property (
		mx && {sink_select_i[13:10], sink_select_i[7:4]} != 8'h0f |=> violation_o[7]
	) else $error("role flag not set");
	AST_WC: assert property (
		mx && !(wa[20:18] > wa[8:6] && wa[23:21] > wa[11:9] && wb[2:0] > wa[14:12])
		|=> violation_o[8]
	) else $error("wetting order flag not set");
	AST_THERMAL: assert property (
		mx && thermal_warning_event_i && (heat_bad(wa[20:18], wa[8:6]) ||
		heat_bad(wa[23:21], wa[11:9]) || heat_bad(wb[2:0], wa[14:12])) |=> violation_o[9]
	) else $error("thermal flag not set");
	AST_NO_MATRIX: assert property (
		|(violation_o[9:4] & ~$past(violation_o[9:4])) |-> $past(mx)
	) else $error("matrix flag set outside 4x4 mode");
	AST_CLEAR: assert property (
		s_quiet_clear |=> violation_o == 10'h000 && config_ok_o
	) else $error("flags not cleared");
endmodule

bind switch_config_rule_checker switch_config_rule_checker_chk #(.THR_W(THR_W)) u_chk (.*);

`default_nettype wire

// [tb/tb_switch_config_rule_checker.sv]
// Self-checking bench: a shadow model feeds the checker from bench configs.
// Assumes the shadow adds one edge, so each result shows two edges later.
`timescale 1ns/1ns
`default_nettype none

module tb_switch_config_rule_checker;
	// ----------------------------------------
	// Stimulus and checks
	// ----------------------------------------
	typedef struct packed {
		logic [10:0][9:0] t;
		logic [1:0]       m;
		logic             p, warn, v, c;
		logic [23:0]      en, md, sk, wa, wb;
	} cfg_s;
	logic       clk_i = 0;
	logic       rstn_i = 0;
	cfg_s       d = '0;
	cfg_s       s, b;
	logic [9:0] ef = 10'h000;
	logic [9:0] vio;
	logic       ok, act, nv = 0, n1v = 0;
	logic [11:0] nexp, n1, e, q[$];
	int         n_errors = 0, compares = 0;

	initial forever #4 clk_i = ~clk_i;

	cfg_shadow_model #(.W($bits(cfg_s))) u_host (.clk_i(clk_i), .rstn_i(rstn_i),
		.d_i(d), .q_o(s));
	switch_config_rule_checker #(.THR_W(10)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
		.check_valid_i(s.v), .clear_i(s.c),
		.level2_low_threshold_i(s.t[0]), .level2_high_threshold_i(s.t[1]),
		.level3_low_threshold_i(s.t[2]), .level3_mid_threshold_i(s.t[3]),
		.level3_high_threshold_i(s.t[4]), .eighth_threshold_i(s.t[5]),
		.ninth_threshold_i(s.t[6]), .supply_set0_low_threshold_i(s.t[7]),
		.supply_set0_high_threshold_i(s.t[8]), .supply_set1_low_threshold_i(s.t[9]),
		.supply_set1_high_threshold_i(s.t[10]), .matrix_size_i(s.m),
		.poll_enable_i(s.p), .input_enable_i(s.en), .conversion_mode_i(s.md),
		.sink_select_i(s.sk), .wetting_current_config_a_i(s.wa),
		.wetting_current_config_b_i(s.wb), .thermal_warning_event_i(s.warn),
		.violation_o(vio), .config_ok_o(ok), .matrix_active_o(act));

	function automatic logic twb(logic [2:0] k, logic [2:0] r);
		return r == 3'h1 ? k > 3'h1 : r == 3'h2 && k == 3'h3;
	endfunction
	// Flags that one sample of a configuration raises.
	function automatic logic [9:0] hits(cfg_s c);
		logic       x;
		logic [9:0] h;
		x = c.m == 2'h1;
		h[0] = c.t[1] < c.t[0];
		h[1] = !(c.t[4] >= c.t[3] && c.t[3] >= c.t[2]);
		h[2] = h[1] || c.t[6] < c.t[5] || c.t[5] < c.t[4];
		h[3] = c.t[8] <= c.t[7] || c.t[10] <= c.t[9];
		h[4] = x && !c.p;
		h[5] = x && !(&c.en[13:10] && &c.en[7:4]);
		h[6] = x && (|c.md[13:10] || |c.md[7:4]);
		h[7] = x && (c.sk[7:4] != 4'hf || c.sk[13:10] != 4'h0);
		h[8] = x && !(c.wa[20:18] > c.wa[8:6] && c.wa[23:21] > c.wa[11:9]
			&& c.wb[2:0] > c.wa[14:12]);
		h[9] = x && c.warn && !(twb(c.wa[20:18], c.wa[8:6])
			&& twb(c.wa[23:21], c.wa[11:9]) && twb(c.wb[2:0], c.wa[14:12]));
		return c.v ? h : 10'h000;
	endfunction
	// A legal 4x4 configuration with a thermal warning expected.
	function automatic cfg_s good();
		cfg_s c;
		c = '0;
		c.t = {10'h0c8, 10'h064, 10'h0c8, 10'h064, 10'h1f4, 10'h190,
			10'h12c, 10'h0c8, 10'h064, 10'h0c8, 10'h064};
		{c.m, c.p, c.warn, c.v} = {2'h1, 3'h7};
		c.en = 24'hff_ffff;
		c.sk = 24'h00_00f0;
		c.wa = 24'h4c_1280;
		c.wb = 24'h00_0002;
		return c;
	endfunction
	// One broken field per entry of the table; from entry 11 on, the warning, valid bit or matrix size is set with it.
	function automatic cfg_s brk(int k);
		cfg_s c;
		c = good();
		case (k)
			0: c.t[1] = 10'h063;
			1: c.t[3] = 10'h12d;
			2: c.t[5] = 10'h1f5;
			3: c.t[8] = 10'h064;
			4: c.p = 0;
			5: c.en[12] = 0;
			6: c.md[5] = 1;
			7: c.sk[11] = 1;
			8: c.wb[2:0] = 3'h1;
			9: c.wa[8:6] = 3'h0;
			10: c.wa[20:18] = 3'h4;
			11: {c.warn, c.wa[20:18]} = {1'b0, 3'h4};
			12: {c.v, c.t[1]} = {1'b0, 10'h063};
			default: {c.p, c.m} = 3'(k - 13);
		endcase
		return c;
	endfunction
	// Drives one configuration and notes the outputs it leads to.
	task automatic put(cfg_s c);
		@(posedge clk_i);
		d <= c;
		ef = (c.c ? 10'h000 : ef) | hits(c);
		nexp <= {ef, ~|ef, c.m == 2'h1};
		nv <= 1;
	endtask
	task automatic cmp_v(logic [9:0] g, logic [9:0] x);
		compares++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic cmp_b(logic g, logic x);
		cmp_v({9'h000, g}, {9'h000, x});
	endtask
	task automatic stop_test;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Delays each note to the edge whose outputs it describes.
	always @(posedge clk_i) begin
		n1 <= nexp;
		n1v <= nv;
		if (n1v) q.push_back(n1);
	end
	// Takes the oldest note whenever a settled result appears.
	always @(negedge clk_i) if (q.size() > 0) begin
		e = q.pop_front();
		cmp_v(vio, e[11:2]);
		cmp_b(ok, e[1]);
		cmp_b(act, e[0]);
	end

	// Table of faults: set, set beats clear, quiet clear, stays clear.
	initial begin
		void'($urandom(32'h96c8_1ef9));
		repeat (12) @(posedge clk_i);
		rstn_i <= 1;
		for (int k = 0; k < 17; k++) begin
			b = brk(k);
			put(b);
			b.c = 1;
			put(b);
			b.v = 0;
			put(b);
			put(good());
			$display("fault case %0d done", k);
		end
		for (int i = 0; i < 400; i++) begin
			b = good();
			b.t[$urandom % 11] = 10'($urandom);
			b.m = 2'($urandom);
			b.wa = 24'($urandom);
			b.v = 1'($urandom);
			b.c = $urandom % 4 == 0;
			put(b);
		end
		$display("random case done");
		@(posedge clk_i);
		nv <= 0;
		repeat (8) @(negedge clk_i);
		if (q.size() != 0) n_errors++;
		stop_test;
	end
	// Cuts a hang short.
	initial begin
		#100000;
		n_errors++;
		stop_test;
	end
endmodule

`default_nettype wire
